// ### logic/fpg_consts.svh
`ifndef FPG_CONSTS_SVH
`define FPG_CONSTS_SVH

// register indices on the plain register port
`define FPG_REG_CTRL 4'h0
`define FPG_REG_LOCK 4'h1
`define FPG_REG_FUSE 4'h2
`define FPG_REG_DENY 4'h3

// control / status register fields
`define FPG_CTRL_BUSY_CLR_BIT 0
`define FPG_STAT_BUSY_BIT 0
`define FPG_STAT_PROG_BIT 1
`define FPG_STAT_STALL_BIT 2

// lock register fields, 1 = unprogrammed
`define FPG_LOCK_GEN_LO_BIT 0
`define FPG_LOCK_GEN_HI_BIT 1
`define FPG_LOCK_APP_LO_BIT 2
`define FPG_LOCK_APP_HI_BIT 3
`define FPG_LOCK_BOOT_LO_BIT 4
`define FPG_LOCK_BOOT_HI_BIT 5
`define FPG_LOCK_RESET 6'h3F

// denial flag fields
`define FPG_DENY_SPM_APP_BIT 0
`define FPG_DENY_SPM_LOCK_BIT 1
`define FPG_DENY_LPM_BIT 2

// fuse register fields
`define FPG_FUSE_BSZ_LSB 0
`define FPG_FUSE_RSTV_BIT 2
`define FPG_FUSE_RESET 3'h7

// value a denied load returns
`define FPG_DENY_DATA 8'hFF

`endif

// ### logic/fpg_pkg.sv
package fpg_pkg;

    typedef enum logic [2:0] {
        FPG_IDLE = 3'b001,
        FPG_PROG_CRR = 3'b010,
        FPG_PROG_STALL = 3'b100
    } fpg_state_e;

    typedef enum logic [1:0] {
        FPG_OP_ERASE = 2'h0,
        FPG_OP_WRITE = 2'h1,
        FPG_OP_LOCK = 2'h2,
        FPG_OP_NONE = 2'h3
    } fpg_op_e;

endpackage

// ### logic/fpg_guard.sv
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "fpg_consts.svh"

// Notes on behaviour
// - store operations executed from the application section never start programming.
// - store from the boot section may target any flash page, locks permitting.
// - boot size fuse sets the app/boot boundary; each section has its own lock pair.
// - programming the concurrent region keeps core running; only stalling region readable.
// - programming the stalling region halts the core for the whole operation.
// - region busy flag reads one while the concurrent region is blocked.
// - boot section always lies wholly inside the stalling region.
// - lock bits only go to programmed; only chip erase returns them to unprogrammed.
// - general lock modes do not gate self-programming stores or loads.
// - both application lock bits unprogrammed: no restriction on application section.
// - low application lock programmed blocks stores to the application section.
// - high application lock programmed denies boot-section loads from application section.
// - high app lock and vectors in boot: suppress interrupts while running application.
// - low boot lock programmed blocks stores to the boot section.
// - high boot lock programmed denies application-section loads from boot section.
// - high boot lock and vectors in application: suppress interrupts while running boot.
// - reset vector is address zero, or boot start when the select fuse is programmed.
module fpg_guard #(
    parameter int AW = 14,
    parameter int BOOT_MIN_WORDS = 512,
    parameter int STALLING_REGION_WORDS = 4096
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [3:0] reg_addr, // register index
    input wire logic [7:0] reg_wdata, // register write data
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    output logic [7:0] reg_rdata_q, // read data, cycle after the strobe
    input wire logic [1:0] boot_size_fuse, // boundary fuse, 1 = unprogrammed
    input wire logic reset_vector_select_fuse, // 0 = start in boot section
    input wire logic [AW-1:0] core_pc, // word address now executing
    input wire logic irq_vec_in_boot, // interrupt vectors relocated to boot
    input wire logic spm_req, // store_prog_mem_op request pulse
    input wire logic [1:0] spm_op, // operation kind
    input wire logic [AW-1:0] spm_addr, // target word address
    input wire logic [5:0] spm_lock_data, // lock bits to program, 0 = program
    input wire logic lpm_req, // program memory load pulse
    input wire logic [AW-1:0] lpm_addr, // load word address
    input wire logic [7:0] flash_rdata, // array data for lpm_addr
    input wire logic flash_done, // array finished erase/write
    input wire logic ext_lock_wr, // external programming lock write
    input wire logic [5:0] ext_lock_data, // external lock bits, 0 = program
    input wire logic chip_erase, // chip erase pulse
    output logic flash_start_q, // start erase/write pulse
    output logic flash_erase_q, // 1 erase, 0 write
    output logic [AW-1:0] flash_addr_q, // latched target address
    output logic core_stall_q, // halt the core
    output logic region_busy_flag_q, // concurrent region blocked
    output logic lpm_valid_q, // load answer valid
    output logic [7:0] lpm_data_q, // load answer
    output logic irq_suppress_q, // mask interrupts
    output logic [AW-1:0] reset_vector_q // reset start address
);

    // flash is a power of two words; both boundaries count down from its top
    localparam logic [AW:0] FLASH_TOP = (AW+1)'(1) << AW;

    fpg_pkg::fpg_state_e state_q, state_d;
    logic [5:0] lock_q, lock_d;
    logic [2:0] fuse_q, fuse_d;
    logic fuse_cap_q, fuse_cap_d;
    logic [2:0] deny_q, deny_d;
    logic busy_q, busy_d;
    logic [7:0] rdata_d;
    logic start_d, erase_d, stall_d, lvalid_d, irqs_d;
    logic [AW-1:0] faddr_d, rstv_d;
    logic [7:0] ldata_d;

    logic [AW:0] boot_words, boot_start_w, stalling_region_start_w;
    logic [AW-1:0] boot_start;
    logic pc_in_boot, tgt_boot, tgt_stall, ld_boot, ld_crr;
    logic app_lo, app_hi, boot_lo, boot_hi;
    logic spm_prog, spm_ok, spm_deny_lock, spm_deny_app, lpm_ok;

    // boundary from the captured fuse; clamped so boot never leaves stalling region
    always_comb begin
        boot_words = (AW+1)'(BOOT_MIN_WORDS) << (~fuse_q[`FPG_FUSE_BSZ_LSB +: 2]);
        if (boot_words > (AW+1)'(STALLING_REGION_WORDS)) begin
            boot_words = (AW+1)'(STALLING_REGION_WORDS);
        end
        boot_start_w = FLASH_TOP - boot_words;
        stalling_region_start_w = FLASH_TOP - (AW+1)'(STALLING_REGION_WORDS);
        boot_start = boot_start_w[AW-1:0];
    end

    always_comb begin
        app_lo = lock_q[`FPG_LOCK_APP_LO_BIT];
        app_hi = lock_q[`FPG_LOCK_APP_HI_BIT];
        boot_lo = lock_q[`FPG_LOCK_BOOT_LO_BIT];
        boot_hi = lock_q[`FPG_LOCK_BOOT_HI_BIT];
        pc_in_boot = {1'b0, core_pc} >= boot_start_w;
        tgt_boot = {1'b0, spm_addr} >= boot_start_w;
        tgt_stall = {1'b0, spm_addr} >= stalling_region_start_w;
        ld_boot = {1'b0, lpm_addr} >= boot_start_w;
        ld_crr = {1'b0, lpm_addr} < stalling_region_start_w;
    end

    // store decision; general lock bits are deliberately not consulted
    // a store from application code is refused before the locks are looked at
    always_comb begin
        spm_prog = spm_req && (spm_op == fpg_pkg::FPG_OP_ERASE || spm_op == fpg_pkg::FPG_OP_WRITE);
        spm_deny_app = spm_req && !pc_in_boot;
        spm_deny_lock = spm_prog && pc_in_boot
            && (tgt_boot ? !boot_lo : !app_lo);
        spm_ok = spm_prog && pc_in_boot && !spm_deny_lock
            && state_q == fpg_pkg::FPG_IDLE;
    end

    // load decision, covers both cross-section locks and the busy region
    // a lock check and the busy check can both refuse; either alone is enough
    always_comb begin
        lpm_ok = 1'b1;
        if (pc_in_boot && !ld_boot && !app_hi) begin
            lpm_ok = 1'b0;
        end
        if (!pc_in_boot && ld_boot && !boot_hi) begin
            lpm_ok = 1'b0;
        end
        if (ld_crr && busy_q) begin
            lpm_ok = 1'b0;
        end
    end

    // programming sequencer
    // one erase or write at a time; a request meanwhile is dropped, not queued
    always_comb begin
        state_d = state_q;
        start_d = 1'b0;
        erase_d = flash_erase_q;
        faddr_d = flash_addr_q;
        stall_d = core_stall_q;
        unique case (state_q)
            fpg_pkg::FPG_IDLE: begin
                if (spm_ok) begin
                    start_d = 1'b1;
                    erase_d = spm_op == fpg_pkg::FPG_OP_ERASE;
                    faddr_d = spm_addr;
                    if (tgt_stall) begin
                        state_d = fpg_pkg::FPG_PROG_STALL;
                        stall_d = 1'b1;
                    end else begin
                        state_d = fpg_pkg::FPG_PROG_CRR;
                    end
                end
            end
            fpg_pkg::FPG_PROG_CRR: begin
                if (flash_done) begin
                    state_d = fpg_pkg::FPG_IDLE;
                end
            end
            fpg_pkg::FPG_PROG_STALL: begin
                if (flash_done) begin
                    state_d = fpg_pkg::FPG_IDLE;
                    stall_d = 1'b0;
                end
            end
        endcase
    end

    // busy flag: set wins over a software clear; clear refused while programming
    // waiting for idle stops software unblocking a region still being written
    always_comb begin
        busy_d = busy_q;
        if (reg_wr && reg_addr == `FPG_REG_CTRL && reg_wdata[`FPG_CTRL_BUSY_CLR_BIT]
            && state_q == fpg_pkg::FPG_IDLE) begin
            busy_d = 1'b0;
        end
        if (spm_ok && !tgt_stall) begin
            busy_d = 1'b1;
        end
    end

    // lock bits only fall; chip erase is the one way back up
    // register, store and external paths may land together; each one only clears bits
    always_comb begin
        lock_d = lock_q;
        if (reg_wr && reg_addr == `FPG_REG_LOCK) begin
            lock_d = lock_d & reg_wdata[5:0];
        end
        if (spm_req && spm_op == fpg_pkg::FPG_OP_LOCK && pc_in_boot) begin
            lock_d = lock_d & spm_lock_data;
        end
        if (ext_lock_wr) begin
            lock_d = lock_d & ext_lock_data;
        end
        if (chip_erase) begin
            lock_d = `FPG_LOCK_RESET;
        end
    end

    // sticky denial flags, write one to clear, new denial wins
    always_comb begin
        deny_d = deny_q;
        if (reg_wr && reg_addr == `FPG_REG_DENY) begin
            deny_d = deny_d & ~reg_wdata[2:0];
        end
        if (spm_deny_app) begin
            deny_d[`FPG_DENY_SPM_APP_BIT] = 1'b1;
        end
        if (spm_deny_lock) begin
            deny_d[`FPG_DENY_SPM_LOCK_BIT] = 1'b1;
        end
        if (lpm_req && !lpm_ok) begin
            deny_d[`FPG_DENY_LPM_BIT] = 1'b1;
        end
    end

    // fuses caught once, on the first edge after reset release
    // a single capture keeps the section boundary from moving under running code
    always_comb begin
        fuse_d = fuse_q;
        fuse_cap_d = 1'b1;
        if (!fuse_cap_q) begin
            fuse_d = {reset_vector_select_fuse, boot_size_fuse};
        end
    end

    // load answer, reset vector, interrupt suppression and register reads
    // a refused load still answers next cycle, so the core never waits on a lock
    always_comb begin
        lvalid_d = lpm_req;
        ldata_d = lpm_data_q;
        if (lpm_req) begin
            ldata_d = lpm_ok ? flash_rdata : `FPG_DENY_DATA;
        end
        rstv_d = fuse_q[`FPG_FUSE_RSTV_BIT] ? '0 : boot_start;
        irqs_d = (!app_hi && irq_vec_in_boot && !pc_in_boot)
            || (!boot_hi && !irq_vec_in_boot && pc_in_boot);
        rdata_d = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `FPG_REG_CTRL: begin
                    rdata_d[`FPG_STAT_BUSY_BIT] = busy_q;
                    rdata_d[`FPG_STAT_PROG_BIT] = state_q != fpg_pkg::FPG_IDLE;
                    rdata_d[`FPG_STAT_STALL_BIT] = core_stall_q;
                end
                `FPG_REG_LOCK: begin
                    rdata_d[5:0] = lock_q;
                end
                `FPG_REG_FUSE: begin
                    rdata_d[2:0] = fuse_q;
                end
                `FPG_REG_DENY: begin
                    rdata_d[2:0] = deny_q;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // lock reset value is a stand-in for nonvolatile cells
    // every output is a flop here, so nothing combinational leaves the block
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= fpg_pkg::FPG_IDLE;
            lock_q <= `FPG_LOCK_RESET;
            fuse_q <= `FPG_FUSE_RESET;
            fuse_cap_q <= 1'b0;
            deny_q <= 3'h0;
            busy_q <= 1'b0;
            reg_rdata_q <= 8'h00;
            flash_start_q <= 1'b0;
            flash_erase_q <= 1'b0;
            flash_addr_q <= '0;
            core_stall_q <= 1'b0;
            lpm_valid_q <= 1'b0;
            lpm_data_q <= 8'h00;
            irq_suppress_q <= 1'b0;
            reset_vector_q <= '0;
        end else begin
            state_q <= state_d;
            lock_q <= lock_d;
            fuse_q <= fuse_d;
            fuse_cap_q <= fuse_cap_d;
            deny_q <= deny_d;
            busy_q <= busy_d;
            reg_rdata_q <= rdata_d;
            flash_start_q <= start_d;
            flash_erase_q <= erase_d;
            flash_addr_q <= faddr_d;
            core_stall_q <= stall_d;
            lpm_valid_q <= lvalid_d;
            lpm_data_q <= ldata_d;
            irq_suppress_q <= irqs_d;
            reset_vector_q <= rstv_d;
        end
    end

    assign region_busy_flag_q = busy_q;

endmodule // fpg_guard

// ### tb/fpg_guard_monitor.sv
`timescale 1ns/1ps
module fpg_guard_monitor #(
    parameter int AW = 14,
    parameter int STALLING_REGION_WORDS = 4096
) (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic [3:0] reg_addr, // index
    input wire logic [7:0] reg_wdata, // data
    input wire logic reg_wr, // write
    input wire logic [AW-1:0] core_pc, // pc
    input wire logic spm_req, // store
    input wire logic lpm_req, // load
    input wire logic [AW-1:0] lpm_addr, // load word
    input wire logic flash_done, // done
    input wire logic flash_start_q, // start
    input wire logic [AW-1:0] flash_addr_q, // target
    input wire logic core_stall_q, // halt
    input wire logic region_busy_flag_q, // busy
    input wire logic lpm_valid_q, // answer
    input wire logic [7:0] lpm_data_q // answer data
);
    localparam logic [AW:0] STALL_LO = (AW+1)'((1 << AW) - STALLING_REGION_WORDS);
    wire clr_wr = reg_wr && reg_addr == 4'h0 && reg_wdata[0];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take_high; flash_start_q && flash_addr_q >= STALL_LO; endsequence
    sequence s_take_low; flash_start_q && flash_addr_q < STALL_LO; endsequence
    sequence s_release; flash_done ##1 !core_stall_q; endsequence
    a_stall_on_high: assert property (s_take_high |-> core_stall_q)
        else $error("no halt on stalling target");
    a_busy_on_low: assert property (s_take_low |-> region_busy_flag_q && !core_stall_q)
        else $error("wrong busy or halt");
    a_stall_holds: assert property (core_stall_q && !flash_done |=> core_stall_q)
        else $error("halt dropped early");
    a_stall_release: assert property (core_stall_q && flash_done |-> s_release)
        else $error("halt not released");
    a_busy_holds: assert property (region_busy_flag_q && !clr_wr |=> region_busy_flag_q)
        else $error("busy dropped uncleared");
    a_load_latency: assert property (lpm_req |=> lpm_valid_q)
        else $error("load answer late");
    a_busy_load_fixed: assert property (lpm_req && region_busy_flag_q && lpm_addr < STALL_LO |=> lpm_data_q == 8'hFF)
        else $error("blocked load leaked");
    a_app_store_off: assert property (spm_req && core_pc < STALL_LO |=> !flash_start_q)
        else $error("store from application ran");
    a_stall_cause: assert property ($rose(core_stall_q) |-> flash_start_q)
        else $error("halt without start");
endmodule // fpg_guard_monitor

bind fpg_guard fpg_guard_monitor #(.AW(AW), .STALLING_REGION_WORDS(STALLING_REGION_WORDS)) u_fpg_guard_monitor (.clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .core_pc, .spm_req, .lpm_req, .lpm_addr, .flash_done, .flash_start_q, .flash_addr_q,
    .core_stall_q, .region_busy_flag_q, .lpm_valid_q, .lpm_data_q);

// ### tb/fpg_flash_model.sv
`timescale 1ns/1ps
module fpg_flash_model (
    input wire logic clk, // clock
    input wire logic rst_n, // reset
    input wire logic [7:0] dly, // cycles per erase/write
    input wire logic start, // erase/write start
    input wire logic [13:0] rd_addr, // load word
    output logic [7:0] rd_data, // array data
    output logic done // finished pulse
);
    logic [7:0] cnt_q;
    // data differs per address so a leaked read is visible
    assign rd_data = rd_addr[7:0] ^ 8'hA5;
    always_ff @(posedge clk) begin
        if (!rst_n || start) cnt_q <= rst_n ? dly : 8'h00;
        else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
        done <= rst_n && cnt_q == 8'h01;
    end
endmodule // fpg_flash_model

// ### tb/flash_self_program_guard_tb.sv
`timescale 1ns/1ps
module flash_self_program_guard_tb;
    localparam logic [13:0] APP = 14'h0100, BOOT = 14'h3E00, HIGH = 14'h3123;
    logic clk, rst_n, reg_wr, reg_rd, reset_vector_select_fuse, irq_vec_in_boot, spm_req, lpm_req, flash_done;
    logic ext_lock_wr, chip_erase, flash_start_q, flash_erase_q, core_stall_q, region_busy_flag_q, lpm_valid_q;
    logic irq_suppress_q;
    logic [1:0] boot_size_fuse, spm_op;
    logic [3:0] reg_addr;
    logic [5:0] spm_lock_data, ext_lock_data;
    logic [7:0] reg_wdata, reg_rdata_q, flash_rdata, lpm_data_q, dly;
    logic [13:0] core_pc, spm_addr, lpm_addr, flash_addr_q, reset_vector_q;
    int error_cnt = 0, compares = 0, cyc = 0;
    fpg_guard u_fpg_guard (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .boot_size_fuse,
        .reset_vector_select_fuse, .core_pc, .irq_vec_in_boot, .spm_req, .spm_op, .spm_addr, .spm_lock_data, .lpm_req,
        .lpm_addr, .flash_rdata, .flash_done, .ext_lock_wr, .ext_lock_data, .chip_erase, .flash_start_q,
        .flash_erase_q, .flash_addr_q, .core_stall_q, .region_busy_flag_q, .lpm_valid_q, .lpm_data_q, .irq_suppress_q,
        .reset_vector_q);
    fpg_flash_model u_fpg_flash_model (.clk, .rst_n, .dly, .start(flash_start_q), .rd_addr(lpm_addr),
        .rd_data(flash_rdata), .done(flash_done));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            close_out();
        end
    end
    task chk(string what, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(logic [3:0] a, logic [7:0] exp, string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(what, 16'(reg_rdata_q), 16'(exp));
    endtask
    task store(logic [1:0] op, logic [13:0] a, logic [5:0] ld);
        @(posedge clk);
        spm_req <= 1'b1;
        spm_op <= op;
        spm_addr <= a;
        spm_lock_data <= ld;
        @(posedge clk);
        spm_req <= 1'b0;
        #1;
    endtask
    task load(logic [13:0] a, logic [7:0] exp);
        @(posedge clk);
        lpm_req <= 1'b1;
        lpm_addr <= a;
        @(posedge clk);
        lpm_req <= 1'b0;
        #1 chk("load", {7'h00, lpm_valid_q, lpm_data_q}, {8'h01, exp});
    endtask
    task xlock(logic [5:0] d);
        @(posedge clk);
        ext_lock_wr <= 1'b1;
        ext_lock_data <= d;
        @(posedge clk);
        ext_lock_wr <= 1'b0;
    endtask
    task wait_done;
        int n;
        n = 0;
        while (flash_done !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("done seen", 16'(flash_done), 16'h0001);
        @(posedge clk);
        #1;
    endtask
    initial begin
        {rst_n, reg_wr, reg_rd, irq_vec_in_boot, spm_req, lpm_req, ext_lock_wr, chip_erase} = '0;
        {reg_addr, reg_wdata, spm_op, spm_addr, spm_lock_data, lpm_addr, ext_lock_data} = '0;
        boot_size_fuse = 2'h3;
        reset_vector_select_fuse = 1'b0;
        core_pc = BOOT;
        dly = 8'h01;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("reset vector", 16'(reset_vector_q), 16'h3E00);
        rd(4'h1, 8'h3F, "lock reset");
        $display("test reset done");
        // one word below the boot start is still application code
        for (int i = 0; i < 2; i++) begin
            core_pc <= i ? 14'h3DFF : APP;
            store(2'h1, HIGH, 6'h3F);
            chk("refused", 16'({flash_start_q, core_stall_q, region_busy_flag_q}), 16'h0000);
        end
        rd(4'h3, 8'h01, "deny flags");
        wr(4'h3, 8'h07);
        $display("test refusal done");
        core_pc <= BOOT;
        irq_vec_in_boot <= 1'b1;
        xlock(6'h3C);
        store(2'h1, HIGH, 6'h3F);
        chk("high start", 16'({flash_start_q, flash_erase_q, core_stall_q, region_busy_flag_q}), 16'h000A);
        chk("target", 16'(flash_addr_q), 16'(HIGH));
        wait_done;
        chk("halt released", 16'(core_stall_q), 16'h0000);
        $display("test stalling write done");
        dly <= 8'h14;
        store(2'h0, APP, 6'h3F);
        chk("low start", 16'({flash_start_q, flash_erase_q, core_stall_q, region_busy_flag_q}), 16'h000D);
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h03, "busy in progress");
        // stray load into the busy region on purpose; the guard must still refuse it
        load(APP, 8'hFF);
        load(HIGH, 8'h86);
        wait_done;
        rd(4'h0, 8'h01, "busy after done");
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h00, "busy cleared");
        load(APP, 8'hA5);
        $display("test concurrent erase done");
        store(2'h2, APP, 6'h33);
        rd(4'h1, 8'h30, "lock bits");
        store(2'h1, APP, 6'h3F);
        chk("app locked", 16'(flash_start_q), 16'h0000);
        load(APP, 8'hFF);
        core_pc <= APP;
        irq_vec_in_boot <= 1'b1;
        @(posedge clk);
        #1 chk("irq in app", 16'(irq_suppress_q), 16'h0001);
        $display("test app locks done");
        xlock(6'h0F);
        load(BOOT, 8'hFF);
        core_pc <= BOOT;
        irq_vec_in_boot <= 1'b0;
        @(posedge clk);
        #1 chk("irq in boot", 16'(irq_suppress_q), 16'h0001);
        store(2'h1, BOOT, 6'h3F);
        chk("boot locked", 16'(flash_start_q), 16'h0000);
        wr(4'h1, 8'h3F);
        rd(4'h1, 8'h00, "locks stay");
        @(posedge clk);
        chip_erase <= 1'b1;
        @(posedge clk);
        chip_erase <= 1'b0;
        rd(4'h1, 8'h3F, "chip erase");
        rd(4'h7, 8'h00, "unmapped");
        $display("test boot locks done");
        // second power-up: application reset vector, largest boot section
        rst_n <= 1'b0;
        reset_vector_select_fuse <= 1'b1;
        boot_size_fuse <= 2'h0;
        core_pc <= 14'h3000;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("vector at zero", 16'(reset_vector_q), 16'h0000);
        chk("irq free", 16'(irq_suppress_q), 16'h0000);
        rd(4'h2, 8'h04, "fuse caught");
        store(2'h3, BOOT, 6'h00);
        rd(4'h1, 8'h3F, "no-op store");
        store(2'h1, APP, 6'h3F);
        chk("big boot store", 16'({flash_start_q, region_busy_flag_q}), 16'h0003);
        wait_done;
        $display("test second reset done");
        close_out();
    end
endmodule // flash_self_program_guard_tb
